// ---- common/spi_status_pkg.sv ----
// Purpose: Shared constants for the serial port status and flag block.
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
// Notes:   Bit positions count from the least significant bit.
package spi_status_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK   = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_PUSH   = 8'h0C;
  localparam logic [7:0] OFF_POP    = 8'h10;

  // ---------------------------------------------------------------------
  // Status field positions
  // ---------------------------------------------------------------------
  localparam int BIT_FRAME_DONE  = 0;
  localparam int BIT_RUN_STATE   = 1;
  localparam int BIT_QUEUE_END   = 3;
  localparam int BIT_TX_UNDER    = 4;
  localparam int BIT_TX_FILL     = 6;
  localparam int BIT_RX_OVER     = 12;
  localparam int BIT_RX_DRAIN    = 14;
  localparam int POS_TX_COUNT    = 16;
  localparam int TX_COUNT_W      = 4;

  // Control field positions.
  localparam int CTL_START       = 0;
  localparam int CTL_HALT        = 1;
  localparam int CTL_MASTER      = 2;
  localparam int CTL_SERIAL_CFG  = 3;
  localparam int CTL_TX_DMA      = 4;
  localparam int CTL_RX_DMA      = 5;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;

  // Mask of all sticky write-one-to-clear flags.
  localparam logic [31:0] W1C_MASK = 32'h0000_5059;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- rtl/spi_status_flags.sv ----
// Purpose: Status, event flags and transmit entry counter of a serial port.
// Assumes: Shifter and FIFO signals come from logic on mclk; the link pins
//          sck and chip select come from outside and are synchronised.
// Notes:   Set conditions win over a software clear in the same cycle.
//
// How it works
// - Flags clear on write of one; fill and drain also by ack.
// - Frame done sets after last bit sampled.
// - Run bit shows stopped or running state.
// - Queue end sets on marked entry finishing.
// - Queue end flag clears the run bit.
// - Queue end only sets in master mode.
// - Underflow: slave, serial, empty, transfer starts.
// - Transmit fill flag set while not full.
// - Transmit fill clears by write or ack.
// - Overflow when receive and shifter full.
// - Receive drain set while FIFO not empty.
// - Receive drain clears by write or ack.
// - Counter tracks pushes minus executed commands.
// - Flags feed interrupt and DMA requests.
// - Post-clock delay follows the frame done event.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module spi_status_flags
  import spi_status_pkg::*;
#(
  parameter int TX_DEPTH   = 4,
  parameter int FRAME_BITS = 8
)(
  input  wire logic        mclk,
  input  wire logic        nrst,
  // AXI4-Lite slave.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Shifter and FIFO side, on mclk.
  input  wire logic        lastBitSampled,
  input  wire logic        queueEndMarker,
  input  wire logic        txLoad,
  input  wire logic        rxEmpty,
  input  wire logic        rxFull,
  input  wire logic        shiftFull,
  input  wire logic [31:0] rxPopData,
  input  wire logic        txDmaAck,
  input  wire logic        rxDmaAck,
  // Link pins.
  input  wire logic        sck,
  input  wire logic        chipSelect_n,
  // Requests and strobes.
  output logic             irq,
  output logic             running,
  output logic             postClockStart,
  output logic             txDmaReq,
  output logic             rxDmaReq,
  output logic             pushStrobe,
  output logic [31:0]      pushData,
  output logic             popStrobe
);

  localparam int CNT_W = $clog2(FRAME_BITS + 1);

  typedef struct packed {
    logic             awready;
    logic             wready;
    logic [7:0]       awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [31:0]      flags;
    logic [TX_COUNT_W-1:0] txCount;
    logic [31:0]      mask;
    logic [31:0]      ctrl;
    logic             running;
    logic             irq;
    logic             postClockStart;
    logic             txDmaReq;
    logic             rxDmaReq;
    logic             pushStrobe;
    logic [31:0]      pushData;
    logic             popStrobe;
    logic [2:0]       csSync;
    logic [2:0]       sckSync;
    logic             csLevel;
    logic             sckLevel;
    logic [CNT_W-1:0] bitCount;
  } state_s;

  state_s cur;
  state_s next_cur;

  // Expands byte strobes into a bit mask.
  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Composes the status word from flags, run bit and counter.
  function automatic logic [31:0] status_word(input state_s s);
    logic [31:0] v;
    v = s.flags & W1C_MASK;
    v[BIT_RUN_STATE] = s.running;
    v[POS_TX_COUNT +: TX_COUNT_W] = s.txCount;
    return v;
  endfunction

  logic [31:0] wrBits;
  logic        doWrite;
  logic        doRead;
  logic        txFull;
  logic        csFall;
  logic        sckRise;
  logic        slaveMode;
  logic        slaveFrameEnd;
  logic        frameEnd;
  logic        xferStart;
  logic [31:0] setBits;
  logic [31:0] clrBits;
  logic [31:0] stat;

  always_comb
  begin
    next_cur = cur;
    next_cur.pushStrobe = 1'b0;
    next_cur.popStrobe = 1'b0;
    next_cur.postClockStart = 1'b0;

    // ---------------------------------------------------------------------
    // Link pin synchronisers
    // ---------------------------------------------------------------------
    next_cur.csSync = {cur.csSync[1:0], chipSelect_n};
    next_cur.sckSync = {cur.sckSync[1:0], sck};
    if (cur.csSync[1] == cur.csSync[2])
    begin
      next_cur.csLevel = cur.csSync[2];
    end
    if (cur.sckSync[1] == cur.sckSync[2])
    begin
      next_cur.sckLevel = cur.sckSync[2];
    end
    csFall = cur.csLevel && !next_cur.csLevel;
    sckRise = !cur.sckLevel && next_cur.sckLevel;
    slaveMode = !cur.ctrl[CTL_MASTER];

    // Slave frames end after the configured number of sampling edges.
    slaveFrameEnd = 1'b0;
    if (!slaveMode || next_cur.csLevel)
    begin
      next_cur.bitCount = '0;
    end
    else if (sckRise)
    begin
      if (cur.bitCount == CNT_W'(FRAME_BITS - 1))
      begin
        next_cur.bitCount = '0;
        slaveFrameEnd = 1'b1;
      end
      else
      begin
        next_cur.bitCount = cur.bitCount + 1'b1;
      end
    end
    frameEnd = slaveMode ? slaveFrameEnd : lastBitSampled;
    xferStart = slaveMode ? csFall : txLoad;

    // ---------------------------------------------------------------------
    // AXI4-Lite handshakes
    // ---------------------------------------------------------------------
    if (awvalid && cur.awready)
    begin
      next_cur.awAddr = awaddr;
      next_cur.awready = 1'b0;
    end
    if (wvalid && cur.wready)
    begin
      next_cur.wData = wdata;
      next_cur.wStrb = wstrb;
      next_cur.wready = 1'b0;
    end
    doWrite = !cur.awready && !cur.wready && !cur.bvalid;
    wrBits = cur.wData & strobe_mask(cur.wStrb);
    if (cur.bvalid && bready)
    begin
      next_cur.bvalid = 1'b0;
      next_cur.awready = 1'b1;
      next_cur.wready = 1'b1;
    end

    doRead = arvalid && cur.arready;
    stat = status_word(cur);
    if (doRead)
    begin
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      case (araddr)
        OFF_STATUS: next_cur.rdata = stat;
        OFF_MASK:   next_cur.rdata = cur.mask;
        OFF_CTRL:   next_cur.rdata = cur.ctrl;
        OFF_PUSH:   next_cur.rdata = cur.pushData;
        OFF_POP:
        begin
          next_cur.rdata = rxPopData;
          next_cur.popStrobe = 1'b1;
        end
        default:
        begin
          next_cur.rdata = '0;
          next_cur.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (cur.rvalid && rready)
    begin
      next_cur.rvalid = 1'b0;
      next_cur.arready = 1'b1;
    end

    // ---------------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------------
    clrBits = '0;
    if (doWrite)
    begin
      next_cur.bvalid = 1'b1;
      next_cur.bresp = RESP_OKAY;
      case (cur.awAddr)
        OFF_STATUS: clrBits = wrBits & W1C_MASK;
        OFF_MASK:   next_cur.mask = (cur.mask & ~strobe_mask(cur.wStrb))
                                    | wrBits;
        OFF_CTRL:   next_cur.ctrl = (cur.ctrl & ~strobe_mask(cur.wStrb))
                                    | wrBits;
        OFF_PUSH:
        begin
          next_cur.pushData = cur.wData;
          next_cur.pushStrobe = 1'b1;
        end
        default:    next_cur.bresp = RESP_SLVERR;
      endcase
    end

    // ---------------------------------------------------------------------
    // Transmit entry counter
    // ---------------------------------------------------------------------
    txFull = cur.txCount >= TX_COUNT_W'(TX_DEPTH);
    if (next_cur.pushStrobe && !txFull && !(txLoad && cur.txCount != '0))
    begin
      next_cur.txCount = cur.txCount + 1'b1;
    end
    else if (!next_cur.pushStrobe && txLoad && cur.txCount != '0)
    begin
      next_cur.txCount = cur.txCount - 1'b1;
    end

    // ---------------------------------------------------------------------
    // Event flags
    // ---------------------------------------------------------------------
    setBits = '0;
    setBits[BIT_FRAME_DONE] = frameEnd;
    setBits[BIT_QUEUE_END] = frameEnd && queueEndMarker && !slaveMode;
    setBits[BIT_TX_UNDER] = slaveMode && cur.ctrl[CTL_SERIAL_CFG]
                            && csFall && cur.txCount == '0;
    setBits[BIT_TX_FILL] = !txFull;
    setBits[BIT_RX_OVER] = xferStart && rxFull && shiftFull;
    setBits[BIT_RX_DRAIN] = !rxEmpty;
    if (txDmaAck && txFull)
    begin
      clrBits[BIT_TX_FILL] = 1'b1;
    end
    if (rxDmaAck && rxEmpty)
    begin
      clrBits[BIT_RX_DRAIN] = 1'b1;
    end
    next_cur.flags = ((cur.flags & ~clrBits) | setBits) & W1C_MASK;
    next_cur.postClockStart = frameEnd;

    // ---------------------------------------------------------------------
    // Run state
    // ---------------------------------------------------------------------
    if (setBits[BIT_QUEUE_END] || next_cur.ctrl[CTL_HALT])
    begin
      next_cur.running = 1'b0;
    end
    else if (doWrite && cur.awAddr == OFF_CTRL && wrBits[CTL_START])
    begin
      next_cur.running = 1'b1;
    end
    next_cur.ctrl[CTL_START] = 1'b0;

    // ---------------------------------------------------------------------
    // Requests
    // ---------------------------------------------------------------------
    next_cur.irq = |(status_word(next_cur) & W1C_MASK & next_cur.mask);
    next_cur.txDmaReq = next_cur.flags[BIT_TX_FILL]
                        && next_cur.ctrl[CTL_TX_DMA];
    next_cur.rxDmaReq = next_cur.flags[BIT_RX_DRAIN]
                        && next_cur.ctrl[CTL_RX_DMA];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur <= '0;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
      cur.mask <= RST_MASK;
      cur.ctrl <= RST_CTRL;
      cur.csSync <= 3'b111;
      cur.csLevel <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign awready = cur.awready;
  assign wready = cur.wready;
  assign bresp = cur.bresp;
  assign bvalid = cur.bvalid;
  assign arready = cur.arready;
  assign rdata = cur.rdata;
  assign rresp = cur.rresp;
  assign rvalid = cur.rvalid;
  assign irq = cur.irq;
  assign running = cur.running;
  assign postClockStart = cur.postClockStart;
  assign txDmaReq = cur.txDmaReq;
  assign rxDmaReq = cur.rxDmaReq;
  assign pushStrobe = cur.pushStrobe;
  assign pushData = cur.pushData;
  assign popStrobe = cur.popStrobe;

endmodule

// ---- verif/spi_status_flags_properties.sv ----
// Purpose: Port assertions for the serial port status block.
// Assumes: A register write takes effect on the cycle bvalid first rises.
// Notes:   Mode and mask state are tracked from observed bus writes.
module spi_status_flags_properties
  import spi_status_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        lastBitSampled,
  input wire logic        queueEndMarker,
  input wire logic        running,
  input wire logic        postClockStart,
  input wire logic        irq,
  input wire logic        popStrobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------------
  // Shadow of mode and mask
  // ---------------------------------------------------------------------
  logic [7:0]  wa;
  logic [31:0] wd;
  logic        bSeen;
  logic        master;
  logic        maskZero;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      {wa, wd, bSeen, master, maskZero} <= 43'h1;
    else
    begin
      if (awvalid && awready) wa <= awaddr;
      if (wvalid && wready) wd <= wdata;
      bSeen <= bvalid;
      if (bvalid && !bSeen && wa == OFF_CTRL) master <= wd[CTL_MASTER];
      if (bvalid && !bSeen && wa == OFF_MASK) maskZero <= (wd == 32'h0);
    end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence sWrTake;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence sQend;
    running && lastBitSampled && queueEndMarker && awready && !awvalid;
  endsequence
  sequence sStatusRead;
    arvalid && arready && araddr == OFF_STATUS;
  endsequence

  AST_PCS_START: assert property (master && lastBitSampled
    |-> ##[1:2] postClockStart) else $error("post clock start missing");
  AST_QEND_STOP: assert property (master ##0 sQend
    |-> ##[1:2] !running) else $error("queue end left run state set");
  AST_QEND_SLAVE: assert property (!master ##0 sQend
    |=> running) else $error("queue end acted in slave mode");
  AST_RUN_READ: assert property (sStatusRead
    |=> rdata[BIT_RUN_STATE] == $past(running)) else $error("run bit read");
  AST_RUN_CAUSE: assert property ($rose(running) |-> bvalid)
    else $error("run state set without a register write");
  // The shadow mask lags the register by one cycle while bvalid stands.
  AST_IRQ_MASK: assert property (maskZero && $past(maskZero, 2)
    && !bvalid |-> !irq) else $error("interrupt with all sources masked");
  AST_POP_STROBE: assert property (arvalid && arready
    && araddr == OFF_POP |=> popStrobe) else $error("pop strobe missing");
  AST_WR_ANSWER: assert property (sWrTake |-> ##[1:2] bvalid)
    else $error("write response late");
  AST_RD_HOLD: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata)) else $error("read data not held");
endmodule

// ---- verif/spi_link_partner.sv ----
// Purpose: External serial master driving chip select and link clock.
// Assumes: The link clock idles low and runs only inside frames.
// Notes:   Edges sit 3 ns off the system clock grid.
module spi_link_partner
(
  output logic sck,
  output logic chipSelect_n
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_NS = 80;

  initial
  begin
    sck = 1'b0;
    chipSelect_n = 1'b1;
  end

  // Selecting the slave starts a transfer.
  task automatic frame(input int bits);
    #3;
    chipSelect_n = 1'b0;
    #HALF_NS;
    repeat (bits)
    begin
      sck = 1'b1;
      #HALF_NS;
      sck = 1'b0;
      #HALF_NS;
    end
    chipSelect_n = 1'b1;
    #(2 * HALF_NS);
  endtask
endmodule

// ---- verif/spi_status_flags_test.sv ----
// Purpose: Self-checking bench for the serial port status block.
// Assumes: Register bus driven as an AXI4-Lite master, one transfer a time.
// Notes:   Random data comes from a fixed-seed shift register.
module spi_status_flags_test
  import spi_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 4;
  localparam int LIMIT = 50;
  logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        queueEndMarker, rxEmpty, rxFull, shiftFull, sck, chipSelect_n;
  logic        awready, wready, bvalid, arready, rvalid, irq, running;
  logic        postClockStart, txDmaReq, rxDmaReq, pushStrobe, popStrobe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rxPopData, pushData, v;
  logic [3:0]  wstrb, pv;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] rnd;
  wire logic   lastBitSampled, txLoad, txDmaAck, rxDmaAck;
  int          errorCnt, testsRun, i;

  assign {rxDmaAck, txDmaAck, txLoad, lastBitSampled} = pv;
  spi_status_flags #(.TX_DEPTH(DEPTH), .FRAME_BITS(8)) uut (.*);
  spi_link_partner link (.sck(sck), .chipSelect_n(chipSelect_n));
  always #5 mclk = ~mclk;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic stopTest();
    $display("mismatches %0d, checks %0d", errorCnt, testsRun);
    if (errorCnt == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    errorCnt++;
    $display("mismatch at %0t: no bus answer", $time);
    stopTest();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge mclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    for (n = 0; n < LIMIT && !bvalid; n++)
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == LIMIT) hang();
    check(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (n = 0; n < LIMIT && !rvalid; n++)
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    {v, r} = {rdata, rresp};
    if (n == LIMIT) hang();
  endtask

  task automatic chkRd(input logic [7:0] a, input logic [31:0] m, e);
    rd(a);
    check({r, v & m}, {RESP_OKAY, e});
  endtask

  task automatic pulse(input logic [3:0] k);
    @(posedge mclk);
    pv <= k;
    @(posedge mclk);
    pv <= 4'h0;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial
  begin
    {mclk, nrst, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {queueEndMarker, rxFull, shiftFull, pv} = 7'h00;
    {awaddr, araddr, wdata, rxPopData} = 80'h0;
    {wstrb, rxEmpty, rnd} = {4'hF, 1'b1, 16'h037E};
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    chkRd(OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0040);
    chkRd(OFF_MASK, 32'hFFFF_FFFF, RST_MASK);
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(8'h40);
    check({r, v}, {RESP_SLVERR, 32'h0});
    for (i = 1; i <= DEPTH + 1; i++)
    begin
      rnd = lfsr(rnd);
      wr(OFF_PUSH, {rnd, ~rnd}, RESP_OKAY);
      check(pushData, {rnd, ~rnd});
      chkRd(OFF_STATUS, 32'h000F_0000, 32'((i > DEPTH ? DEPTH : i) << 16));
    end
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    chkRd(OFF_STATUS, 32'h40, 32'h40);
    wr(OFF_STATUS, 32'h40, RESP_OKAY);
    chkRd(OFF_STATUS, 32'h40, 32'h0);
    pulse(4'h2);
    chkRd(OFF_STATUS, 32'h000F_0040, 32'h0003_0040);
    wr(OFF_PUSH, 32'h0, RESP_OKAY);
    pulse(4'h4);
    chkRd(OFF_STATUS, 32'h000F_0040, 32'h0004_0000);
    repeat (DEPTH) pulse(4'h2);
    wr(OFF_CTRL, 32'h5, RESP_OKAY);
    chkRd(OFF_STATUS, 32'h2, 32'h2);
    pulse(4'h1);
    chkRd(OFF_STATUS, 32'hB, 32'h3);
    queueEndMarker <= 1'b1;
    pulse(4'h1);
    chkRd(OFF_STATUS, 32'hB, 32'h9);
    wr(OFF_MASK, 32'h1, RESP_OKAY);
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    check(irq, 32'h1);
    wr(OFF_STATUS, 32'h9, RESP_OKAY);
    chkRd(OFF_STATUS, 32'hF, 32'h0);
    check(irq, 32'h0);
    wr(OFF_CTRL, 32'h9, RESP_OKAY);
    {rxFull, shiftFull} <= 2'h3;
    link.frame(8);
    pulse(4'h1);
    chkRd(OFF_STATUS, 32'h101B, 32'h1013);
    check(irq, 32'h1);
    rnd = lfsr(rnd);
    {rxFull, shiftFull, rxEmpty, rxPopData} <= {3'h0, rnd, ~rnd};
    wr(OFF_CTRL, 32'h38, RESP_OKAY);
    chkRd(OFF_STATUS, 32'h4000, 32'h4000);
    check(rxDmaReq, 32'h1);
    check(txDmaReq, 32'h1);
    chkRd(OFF_POP, 32'hFFFF_FFFF, {rnd, ~rnd});
    rxEmpty <= 1'b1;
    pulse(4'h8);
    chkRd(OFF_STATUS, 32'h4000, 32'h0);
    check(rxDmaReq, 32'h0);
    stopTest();
  end
endmodule

bind spi_status_flags spi_status_flags_properties chk (.*);
